// *** fdp_cfg.svh ***
// Register map, field positions and reset values of the fixed duty PWM block
`ifndef FDP_CFG_SVH
`define FDP_CFG_SVH
`define FDP_ADR_CTRL   8'h00
`define FDP_ADR_FRAC   8'h04
`define FDP_ADR_STEER0 8'h08
`define FDP_ADR_STEER1 8'h0C
`define FDP_ADR_DBR    8'h10
`define FDP_ADR_DBF    8'h14
`define FDP_ADR_STAT   8'h18
`define FDP_CTRL_EN    0
`define FDP_CTRL_MODE  3:1
`define FDP_CTRL_DBRE  4
`define FDP_CTRL_DBFE  5
`define FDP_CTRL_LD    6
`define FDP_STR1_HS    0
`define FDP_STR1_LS    1
`define FDP_RST_BYTE   8'h00
`define FDP_RST_OUT    6'h00
`endif

// *** fdp_drv_model.sv ***
// Half-bridge switch driver model that flags shoot-through on any leg
`timescale 1ns/1ps
module fdp_drv_model (
    // Clock
    input  wire logic       clk_i,
    // Gate drives, output_a..output_f
    input  wire logic [5:0] out_i,
    // Sticky fault seen by the bench
    output logic            shoot_o
);
    initial shoot_o = 1'b0;
    // Both switches of one leg on would short the rail, so this is latched, never cleared
    always @(posedge clk_i)
    begin
        if ((out_i[0] & out_i[1]) | (out_i[2] & out_i[3]) | (out_i[4] & out_i[5]))
            shoot_o <= 1'b1;
    end
endmodule : fdp_drv_model

// *** fdp_pkg.sv ***
// Types shared by the fixed duty PWM block
package fdp_pkg;
    typedef enum logic [2:0] {
        MODE_SINGLE,
        MODE_COMPL,
        MODE_3PH,
        MODE_FB_FWD,
        MODE_FB_REV
    } fdp_mode_e;

    typedef struct packed {
        logic        en;
        logic [2:0]  mode;
        logic        dbr_en;
        logic        dbf_en;
        logic        ld_pend;
        logic [3:0]  frac;
        logic [5:0]  steer;
        logic        hs_en;
        logic        ls_en;
        logic [7:0]  dbr_reg;
        logic [7:0]  dbf_reg;
        logic [7:0]  dbr_act;
        logic [7:0]  dbf_act;
        logic [3:0]  acc;
        logic        carry;
        logic        lvl;
        logic        rise_run;
        logic        fall_run;
        logic [7:0]  rcnt;
        logic [7:0]  fcnt;
        logic        dir_rev;
        logic [5:0]  out;
        logic        ack;
        logic [31:0] dat;
    } fdp_state_s;
endpackage : fdp_pkg

// *** fdp_top.sv ***
// Fixed duty, 3-phase steering and dead-band output stage with Wishbone registers
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fdp_cfg.svh"
module fdp_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Time base strobes
    input  wire logic        period_i,
    input  wire logic        rise_i,
    input  wire logic        fall_i,
    input  wire logic        load_i,
    // Outputs to the switch drivers and the time base
    output logic [5:0]       out_o,
    output logic             frac_carry_o
);
    // High and low output index of each steering bit
    localparam logic [17:0] HI_IDX = {3'd4, 3'd4, 3'd2, 3'd2, 3'd0, 3'd0};
    localparam logic [17:0] LO_IDX = {3'd3, 3'd1, 3'd1, 3'd5, 3'd5, 3'd3};

    fdp_pkg::fdp_state_s q;
    fdp_pkg::fdp_state_s d;
    fdp_pkg::fdp_mode_e  mode;
    logic                wr;
    logic                rd_ok;
    logic                ev_r;
    logic                ev_f;
    logic [4:0]          sum;
    logic [5:0]          pick;
    logic [2:0]          hi;
    logic [2:0]          lo;
    logic                want_rev;

    assign mode = fdp_pkg::fdp_mode_e'(q.mode);
    assign wr   = cyc_i && stb_i && we_i && !q.ack && sel_i[0];

    // Lowest set steering bit wins; loop runs high to low so it overrides
    always_comb
    begin
        pick = 6'h00;
        hi   = 3'd0;
        lo   = 3'd0;
        for (int i = 5; i >= 0; i--)
        begin
            if (q.steer[i])
            begin
                pick = 6'h00;
                pick[HI_IDX[3*i +: 3]] = 1'b1;
                pick[LO_IDX[3*i +: 3]] = 1'b1;
                hi = HI_IDX[3*i +: 3];
                lo = LO_IDX[3*i +: 3];
            end
        end
    end

    always_comb
    begin
        d = q;
        d.ack = cyc_i && stb_i && !q.ack;
        d.carry = 1'b0;
        ev_r = 1'b0;
        ev_f = 1'b0;
        rd_ok = 1'b1;
        want_rev = (mode == fdp_pkg::MODE_FB_REV);
        sum = {1'b0, q.acc} + {1'b0, q.frac};

        // Register writes; only the low byte lane carries data
        if (wr)
        begin
            case (adr_i)
                `FDP_ADR_CTRL:
                begin
                    d.en     = dat_i[`FDP_CTRL_EN];
                    d.mode   = dat_i[`FDP_CTRL_MODE];
                    d.dbr_en = dat_i[`FDP_CTRL_DBRE];
                    d.dbf_en = dat_i[`FDP_CTRL_DBFE];
                end
                `FDP_ADR_FRAC:   d.frac = dat_i[3:0];
                `FDP_ADR_STEER0: d.steer = dat_i[5:0];
                `FDP_ADR_STEER1:
                begin
                    d.hs_en = dat_i[`FDP_STR1_HS];
                    d.ls_en = dat_i[`FDP_STR1_LS];
                end
                `FDP_ADR_DBR:    d.dbr_reg = dat_i[7:0];
                `FDP_ADR_DBF:    d.dbf_reg = dat_i[7:0];
                default:         d.en = q.en;
            endcase
        end

        // Buffered dead-band times move to the counters at a period event with a load pending, at once while disabled
        if (!q.en)
        begin
            d.dbr_act = d.dbr_reg;
            d.dbf_act = d.dbf_reg;
            d.ld_pend = 1'b0;
        end
        else if (period_i && q.ld_pend)
        begin
            d.dbr_act = q.dbr_reg;
            d.dbf_act = q.dbf_reg;
            d.ld_pend = 1'b0;
        end
        // Setting the load flag wins over the clear in the same cycle
        if (load_i || (wr && adr_i == `FDP_ADR_CTRL && dat_i[`FDP_CTRL_LD]))
            d.ld_pend = 1'b1;

        if (!q.en)
        begin
            d.out = `FDP_RST_OUT;
            d.acc = 4'h0;
            d.lvl = 1'b0;
            d.rise_run = 1'b0;
            d.fall_run = 1'b0;
            d.dir_rev = 1'b0;
        end
        else
        begin
            case (mode)
                fdp_pkg::MODE_SINGLE:
                begin
                    d.out[5:1] = 5'h00;
                    if (period_i)
                    begin
                        d.out[0] = !q.out[0];
                        d.acc = sum[3:0];
                        d.carry = sum[4];
                    end
                end
                fdp_pkg::MODE_COMPL:
                begin
                    d.out[5:2] = 4'h0;
                    if (period_i)
                    begin
                        d.lvl = !q.lvl;
                        d.acc = sum[3:0];
                        d.carry = sum[4];
                        ev_r = !q.lvl;
                        ev_f = q.lvl;
                    end
                    if (ev_r)
                    begin
                        d.out[1] = 1'b0;
                        d.fall_run = 1'b0;
                        d.rise_run = q.dbr_en;
                        d.rcnt = 8'h00;
                        d.out[0] = !q.dbr_en;
                    end
                    else if (ev_f)
                    begin
                        d.out[0] = 1'b0;
                        d.rise_run = 1'b0;
                        d.fall_run = q.dbf_en;
                        d.fcnt = 8'h00;
                        d.out[1] = !q.dbf_en;
                    end
                    else
                    begin
                        // Counters step each clock; a zero time still costs one cycle
                        if (q.rise_run)
                        begin
                            if (!q.dbr_en || q.rcnt == q.dbr_act)
                            begin
                                d.rise_run = 1'b0;
                                d.out[0] = 1'b1;
                            end
                            else
                                d.rcnt = q.rcnt + 8'h01;
                        end
                        if (q.fall_run)
                        begin
                            if (!q.dbf_en || q.fcnt == q.dbf_act)
                            begin
                                d.fall_run = 1'b0;
                                d.out[1] = 1'b1;
                            end
                            else
                                d.fcnt = q.fcnt + 8'h01;
                        end
                    end
                end
                fdp_pkg::MODE_3PH:
                begin
                    if (rise_i)
                        d.lvl = 1'b1;
                    else if (fall_i)
                        d.lvl = 1'b0;
                    d.rise_run = 1'b0;
                    d.fall_run = 1'b0;
                    d.out = 6'h00;
                    d.out[hi] = pick[hi] && (q.hs_en ? d.lvl : 1'b1);
                    d.out[lo] = pick[lo] && (q.ls_en ? d.lvl : 1'b1);
                end
                fdp_pkg::MODE_FB_FWD, fdp_pkg::MODE_FB_REV:
                begin
                    if (rise_i)
                        d.lvl = 1'b1;
                    else if (fall_i)
                        d.lvl = 1'b0;
                    d.out[5:4] = 2'b00;
                    if (want_rev != q.dir_rev && !q.rise_run && !q.fall_run)
                    begin
                        // Forward to reverse uses the falling count, back uses rising
                        d.out[3:0] = 4'h0;
                        d.rcnt = 8'h00;
                        d.fcnt = 8'h00;
                        d.fall_run = want_rev && q.dbf_en;
                        d.rise_run = !want_rev && q.dbr_en;
                        if (!d.fall_run && !d.rise_run)
                            d.dir_rev = want_rev;
                    end
                    else if (q.rise_run || q.fall_run)
                    begin
                        d.out[3:0] = 4'h0;
                        if (q.fall_run && (!q.dbf_en || q.fcnt == q.dbf_act))
                        begin
                            d.fall_run = 1'b0;
                            d.dir_rev = want_rev;
                        end
                        else if (q.rise_run && (!q.dbr_en || q.rcnt == q.dbr_act))
                        begin
                            d.rise_run = 1'b0;
                            d.dir_rev = want_rev;
                        end
                        else
                        begin
                            d.fcnt = q.fcnt + 8'h01;
                            d.rcnt = q.rcnt + 8'h01;
                        end
                    end
                    else if (q.dir_rev)
                        d.out[3:0] = {1'b0, 1'b1, d.lvl, 1'b0};
                    else
                        d.out[3:0] = {1'b1, 1'b0, 1'b0, d.lvl};
                end
                default:
                    d.out = `FDP_RST_OUT;
            endcase
        end

        // Read data is registered together with ack
        d.dat = 32'h0000_0000;
        if (cyc_i && stb_i && !we_i && !q.ack)
        begin
            case (adr_i)
                `FDP_ADR_CTRL:
                    d.dat[6:0] = {q.ld_pend, q.dbf_en, q.dbr_en, q.mode, q.en};
                `FDP_ADR_FRAC:   d.dat[3:0] = q.frac;
                `FDP_ADR_STEER0: d.dat[5:0] = q.steer;
                `FDP_ADR_STEER1: d.dat[1:0] = {q.ls_en, q.hs_en};
                `FDP_ADR_DBR:    d.dat[7:0] = q.dbr_reg;
                `FDP_ADR_DBF:    d.dat[7:0] = q.dbf_reg;
                `FDP_ADR_STAT:
                    d.dat[15:0] = {q.fall_run, q.rise_run, q.acc, q.lvl, q.dir_rev, 2'b00, q.out};
                default:         rd_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.mode <= 3'(fdp_pkg::MODE_SINGLE);
            q.dbr_reg <= `FDP_RST_BYTE;
            q.dbf_reg <= `FDP_RST_BYTE;
        end
        else
            q <= d;
    end

    assign dat_o = q.dat;
    assign ack_o = q.ack;
    assign out_o = q.out;
    assign frac_carry_o = q.carry;

    single_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && mode == fdp_pkg::MODE_SINGLE && period_i |=> out_o[0] != $past(out_o[0]))
        else $error("single mode did not toggle output_a");
    single_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && mode == fdp_pkg::MODE_SINGLE && !wr |=> out_o[5:1] == 5'h00)
        else $error("single mode drives other outputs");
    acc_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && mode == fdp_pkg::MODE_COMPL && period_i
        |=> {frac_carry_o, q.acc} == {1'b0, $past(q.acc)} + {1'b0, $past(q.frac)})
        else $error("fractional accumulator did not step");
    compl_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && mode == fdp_pkg::MODE_COMPL && period_i && !q.lvl && q.dbr_en && !wr
        |=> !out_o[1] && !out_o[0] && q.rise_run)
        else $error("rising dead band did not start");
    db_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && mode == fdp_pkg::MODE_COMPL && q.rise_run && q.dbr_en
        && q.rcnt == q.dbr_act && !period_i |=> out_o[0] && !q.rise_run)
        else $error("primary not raised at end of dead band");
    overlap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && mode == fdp_pkg::MODE_COMPL && period_i && q.lvl && q.rise_run && !wr
        |=> !out_o[0] && !q.rise_run)
        else $error("rising count not ended by falling event");
    three_ph_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && mode == fdp_pkg::MODE_3PH |=> $countones(out_o) <= 2)
        else $error("more than two outputs active in 3-phase mode");
    hold_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && mode == fdp_pkg::MODE_3PH && !q.hs_en && !q.ls_en && q.steer == 6'h03 && !wr
        |=> out_o == 6'h09)
        else $error("steering hold state wrong");
    ld_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.en && period_i && q.ld_pend && !wr
        |=> q.dbr_act == $past(q.dbr_reg) && q.dbf_act == $past(q.dbf_reg)
        && q.ld_pend == $past(load_i))
        else $error("dead-band time not loaded at period event");
    unused_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !we_i && !q.ack && !rd_ok |=> ack_o && dat_o == 32'h0)
        else $error("unmapped read not answered with zero");
endmodule : fdp_top

// *** test_fixed_duty_3phase_deadband_pwm.sv ***
// Self-checking bench of the fixed duty, 3-phase and dead-band output stage
`timescale 1ns/1ps
`include "fdp_cfg.svh"
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("mismatch at %0t: %s", $time, m); end end
module test_fixed_duty_3phase_deadband_pwm;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic        ack_o, frac_carry_o, shoot;
    logic        period_i = 1'b0, rise_i = 1'b0, fall_i = 1'b0, load_i = 1'b0;
    logic [5:0]  out_o, ex;
    logic [3:0]  acc, fr;
    logic        lvl;
    int          fails = 0, tests_run = 0, i, k;
    logic [5:0]  codes [13];

    fdp_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .period_i(period_i), .rise_i(rise_i), .fall_i(fall_i), .load_i(load_i),
        .out_o(out_o), .frac_carry_o(frac_carry_o));
    fdp_drv_model drv_u (.clk_i(clk_i), .out_i(out_o), .shoot_o(shoot));

    always #50 clk_i = ~clk_i;

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    // One classic cycle; read data and the write land at the acked edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            fails++;
            $display("mismatch at %0t: no ack", $time);
        end
        r = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    // Strobe mask bit0 period, bit1 rise, bit2 fall; returns just after the sampling edge
    task automatic ev(input logic [2:0] m);
        @(posedge clk_i);
        period_i <= m[0]; rise_i <= m[1]; fall_i <= m[2];
        @(posedge clk_i);
        period_i <= 1'b0; rise_i <= 1'b0; fall_i <= 1'b0;
        #1;
    endtask : ev

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_n

    function automatic logic [31:0] ctrl(input logic [2:0] md, input logic re, input logic fe,
                                         input logic ld);
        logic [31:0] c;
        c = 32'h0;
        c[`FDP_CTRL_EN] = 1'b1;
        c[`FDP_CTRL_MODE] = md;
        c[`FDP_CTRL_DBRE] = re;
        c[`FDP_CTRL_DBFE] = fe;
        c[`FDP_CTRL_LD] = ld;
        return c;
    endfunction : ctrl

    // Pair of the lowest set steering bit
    function automatic logic [5:0] pair(input logic [5:0] s);
        if (s[0]) return 6'h09;
        if (s[1]) return 6'h21;
        if (s[2]) return 6'h24;
        if (s[3]) return 6'h06;
        if (s[4]) return 6'h12;
        if (s[5]) return 6'h18;
        return 6'h00;
    endfunction : pair

    // Complementary transition; on means output_a goes active after n+1 dead cycles
    task automatic db_edge(input logic on, input int n);
        ev(3'h1);
        `CHK(out_o[1:0], 2'b00, "both off at edge")
        wait_n(n);
        `CHK(out_o[1:0], 2'b00, "still dead")
        wait_n(1);
        `CHK(out_o[1:0], on ? 2'b01 : 2'b10, "driven after dead band")
    endtask : db_edge

    initial
    begin
        #(100 * 20000);
        fails++;
        $display("mismatch at %0t: watchdog", $time);
        stop_test();
    end

    initial
    begin
        k = $urandom(84);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `FDP_ADR_CTRL, 32'h0, rd);
        `CHK(rd, 32'h0, "control reset value")
        `CHK(out_o, `FDP_RST_OUT, "outputs at reset")
        wr(8'h1C, 32'hFF);
        wb(1'b0, 8'h1C, 32'h0, rd);
        `CHK(rd, 32'h0, "unmapped reads zero")
        $display("test registers done");

        wr(`FDP_ADR_CTRL, ctrl(fdp_pkg::MODE_SINGLE, 1'b1, 1'b1, 1'b0));
        acc = 4'h0;
        lvl = 1'b0;
        for (i = 0; i < 10; i++)
        begin
            fr = (i == 0) ? 4'hF : 4'($urandom());
            wr(`FDP_ADR_FRAC, {28'h0, fr});
            ev(3'h6);
            `CHK(out_o, {5'h0, lvl}, "rise and fall ignored")
            ev(3'h1);
            lvl = ~lvl;
            `CHK(frac_carry_o, ({1'b0, acc} + {1'b0, fr}) > 5'h0F, "fraction carry")
            acc = acc + fr;
            `CHK(out_o, {5'h0, lvl}, "toggle on period")
            wb(1'b0, `FDP_ADR_STAT, 32'h0, rd);
            `CHK(rd[13:10], acc, "accumulator sum")
        end
        $display("test single done");

        wr(`FDP_ADR_CTRL, 32'h0);
        wr(`FDP_ADR_DBR, 32'h2);
        wr(`FDP_ADR_DBF, 32'h3);
        wr(`FDP_ADR_CTRL, ctrl(fdp_pkg::MODE_COMPL, 1'b1, 1'b1, 1'b0));
        db_edge(1'b1, 2);
        db_edge(1'b0, 3);
        wr(`FDP_ADR_DBR, 32'h6);
        db_edge(1'b1, 2);
        wr(`FDP_ADR_CTRL, ctrl(fdp_pkg::MODE_COMPL, 1'b1, 1'b1, 1'b1));
        db_edge(1'b0, 3);
        // Turn-off lands inside the rising count
        ev(3'h1);
        ev(3'h1);
        for (i = 0; i < 8; i++)
        begin
            `CHK(out_o[0], 1'b0, "primary suppressed")
            wait_n(1);
        end
        `CHK(out_o[1:0], 2'b10, "falling count took over")
        db_edge(1'b1, 6);
        // Turn-on lands inside the falling count
        ev(3'h1);
        ev(3'h1);
        for (i = 0; i < 8; i++)
        begin
            `CHK(out_o[1], 1'b0, "complementary suppressed")
            wait_n(1);
        end
        `CHK(out_o[1:0], 2'b01, "rising count took over")
        // New falling time reaches the counter through the time base load strobe
        wr(`FDP_ADR_DBF, 32'h2);
        @(posedge clk_i);
        load_i <= 1'b1;
        @(posedge clk_i);
        load_i <= 1'b0;
        db_edge(1'b0, 2);
        $display("test complementary done");

        wr(`FDP_ADR_CTRL, ctrl(fdp_pkg::MODE_3PH, 1'b0, 1'b0, 1'b0));
        wr(`FDP_ADR_STEER1, 32'h0);
        codes = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3F, 6'h30, 6'h03,
                  6'h0, 6'h0, 6'h0};
        for (i = 10; i < 13; i++)
            codes[i] = 6'($urandom());
        for (i = 0; i < 13; i++)
        begin
            wr(`FDP_ADR_STEER0, {26'h0, codes[i]});
            ev(3'h4);
            `CHK(out_o, pair(codes[i]), "steered pair held")
        end
        wr(`FDP_ADR_STEER0, 32'h01);
        for (k = 0; k < 2; k++)
        begin
            wr(`FDP_ADR_STEER1, 32'h1 << k);
            ex = pair(6'h01) & (k == 0 ? 6'h2A : 6'h15);
            ev(3'h4);
            `CHK(out_o, ex, "modulated side off on fall")
            ev(3'h1);
            `CHK(out_o, ex, "period ignored in 3-phase")
            ev(3'h2);
            `CHK(out_o, pair(6'h01), "modulated side on at rise")
        end
        `CHK(shoot, 1'b0, "no leg shoot-through")
        $display("test three phase done");

        // Disabling reloads the active times: rising 6, falling 2
        wr(`FDP_ADR_CTRL, 32'h0);
        wr(`FDP_ADR_CTRL, ctrl(fdp_pkg::MODE_FB_FWD, 1'b1, 1'b1, 1'b0));
        ev(3'h2);
        `CHK(out_o, 6'h09, "forward drive follows rise")
        wr(`FDP_ADR_CTRL, ctrl(fdp_pkg::MODE_FB_REV, 1'b1, 1'b1, 1'b0));
        wait_n(3);
        `CHK(out_o, 6'h00, "bridge dead on reverse")
        wait_n(1);
        `CHK(out_o, 6'h06, "reverse after falling count")
        ev(3'h4);
        `CHK(out_o, 6'h04, "reverse drive follows fall")
        wr(`FDP_ADR_CTRL, ctrl(fdp_pkg::MODE_FB_FWD, 1'b1, 1'b1, 1'b0));
        wait_n(7);
        `CHK(out_o, 6'h00, "bridge dead on forward")
        wait_n(1);
        `CHK(out_o, 6'h08, "forward after rising count")
        `CHK(shoot, 1'b0, "no bridge leg shoot-through")
        $display("test full bridge done");
        stop_test();
    end
endmodule : test_fixed_duty_3phase_deadband_pwm
